/* File: logic/imuos_pkg.sv */
// Package for the output scheduler: register map, rates, timing constants.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package imuos_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int PROC_RATE_HZ = 200;
	localparam int PROC_DIV = CLK_HZ / PROC_RATE_HZ;
	localparam int SYNC_RATE_HZ = 1000;
	localparam int SYNC_DIV = CLK_HZ / SYNC_RATE_HZ;
	localparam int WIDTH_LIMIT_PCT = 80;
	localparam int BITS_PER_CHAR = 10;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [7:0] REG_SEQ = 8'h14;
	localparam logic [7:0] REG_PORT_SEL = 8'h18;
	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_GET_PKT_BIT = 0;
	localparam int CTRL_BURST_BIT = 1;
	localparam int IRQ_SPI_BIT = 0;
	localparam int IRQ_UART_BIT = 1;
	localparam int IRQ_REJ_BIT = 2;
	localparam int IRQ_SYNC_BIT = 3;
	localparam int IRQ_W = 4;
	localparam logic [1:0] BAUD_DEFAULT = 2'h0;
	localparam logic [2:0] RATE_DEFAULT = 3'h1;
	localparam logic [7:0] LEN_DEFAULT = 8'h18;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// Baud codes: 38400, 57600, 115200, 230400
	typedef enum logic [1:0] {B38400, B57600, B115200, B230400} imuos_baud_type;
	// Rate codes: quiet, 100, 50, 25, 20, 10, 5, 2 Hz
	typedef enum logic [2:0] {
		R_QUIET, R_100, R_50, R_25, R_20, R_10, R_5, R_2
	} imuos_rate_type;
	typedef struct packed {
		logic [7:0] pkt_len;
		logic pkt_scaled;
		imuos_rate_type rate;
		imuos_baud_type baud;
	} imuos_cfg_type;
	typedef struct packed {
		logic [15:0] seq;
		logic [2:0] fault;
	} imuos_meas_type;
	// ----------------------------------------------------------------
	// Packet and rate decoding
	// ----------------------------------------------------------------
	function automatic logic [31:0] imuos_rate_hz(input imuos_rate_type r);
		case (r)
			R_100: imuos_rate_hz = 32'h64;
			R_50: imuos_rate_hz = 32'h32;
			R_25: imuos_rate_hz = 32'h19;
			R_20: imuos_rate_hz = 32'h14;
			R_10: imuos_rate_hz = 32'h0a;
			R_5: imuos_rate_hz = 32'h05;
			R_2: imuos_rate_hz = 32'h02;
			default: imuos_rate_hz = 32'h00;
		endcase
	endfunction : imuos_rate_hz
	function automatic logic [31:0] imuos_baud_bps(input imuos_baud_type b);
		case (b)
			B57600: imuos_baud_bps = 32'he100;
			B115200: imuos_baud_bps = 32'h1c200;
			B230400: imuos_baud_bps = 32'h38400;
			default: imuos_baud_bps = 32'h9600;
		endcase
	endfunction : imuos_baud_bps
	// Packet time within 80% of interval: bits*rate*100 <= baud*80
	function automatic logic imuos_cfg_ok(input imuos_cfg_type c);
		logic [63:0] lhs;
		logic [63:0] rhs;
		lhs = 64'(c.pkt_len) * 64'(BITS_PER_CHAR) * 64'(imuos_rate_hz(c.rate))
			* 64'd100;
		rhs = 64'(imuos_baud_bps(c.baud)) * 64'(WIDTH_LIMIT_PCT);
		imuos_cfg_ok = (lhs <= rhs);
	endfunction : imuos_cfg_ok
	// UART periods in system clocks
	function automatic logic [31:0] imuos_uart_div(input imuos_rate_type r);
		imuos_uart_div = (r == R_QUIET) ? 32'h0 :
			32'(CLK_HZ) / imuos_rate_hz(r);
	endfunction : imuos_uart_div
endpackage : imuos_pkg

/* File: logic/imuos_scheduler.sv */
// Output scheduler: 200 Hz processing chain sequencing, SPI register
// refresh, UART packet pacing, width check, port select and interrupts.
// Assumes sensor samples are ready on each processing tick and that
// sync_in and port_sel_in are synchronous to aclk.
// Notes on behaviour
// - Processing chain ticks at fixed 200 Hz
// - Output registers hold latest set, refresh 200Hz
// - UART packets at chosen fixed rate
// - One packet per get-packet request
// - Packet time at most 80% of interval
// - Refuse settings breaking the width limit
// - Single register reads
// - Align output data to 1 kHz sync in SPI mode
// - Calibrate each sample before axis rotation
// - Fault detect per sensor, then combine
// - Scaled packet carries engineering units
// - Sync rising edge forces collection timing in SPI mode
// - Sample port select at startup; drive ready in SPI mode
`timescale 1ns/1ps
module imuos_scheduler #(
	parameter int PROC_DIV = imuos_pkg::PROC_DIV,
	parameter int SYNC_DIV = imuos_pkg::SYNC_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sync_in,
	input wire logic port_sel_in,
	output logic port_sel_out,
	output logic port_sel_oe,
	input wire logic [2:0] sensor_fault_in,
	output logic [2:0] chain_stage,
	output logic spi_mode,
	output logic uart_pkt_start,
	output logic uart_pkt_scaled,
	output logic [15:0] out_seq,
	output logic irq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum {ST_IDLE, ST_FILT, ST_CAL, ST_ROT, ST_FAULT,
		ST_COMB} imuos_state_type;
	imuos_state_type st, next_st;
	logic [31:0] pcnt, next_pcnt;
	logic [31:0] scnt, next_scnt;
	logic [31:0] ucnt, next_ucnt;
	logic sync_d, next_sync_d;
	logic sync_seen, next_sync_seen;
	logic started, next_started;
	logic spi_m, next_spi_m;
	imuos_pkg::imuos_cfg_type cfg, next_cfg;
	imuos_pkg::imuos_meas_type work, next_work;
	imuos_pkg::imuos_meas_type outreg, next_outreg;
	logic [15:0] seq, next_seq;
	logic [imuos_pkg::IRQ_W-1:0] ist, next_ist;
	logic [imuos_pkg::IRQ_W-1:0] imask, next_imask;
	logic gp_pend, next_gp_pend;
	logic uart_go, next_uart_go;
	logic drdy, next_drdy;
	logic aw_h, next_aw_h, w_h, next_w_h;
	logic [7:0] awa, next_awa;
	logic [31:0] wd, next_wd;
	logic bv, next_bv;
	logic [1:0] br, next_br;
	logic rv, next_rv;
	logic [1:0] rr, next_rr;
	logic [31:0] rd, next_rd;
	imuos_pkg::imuos_cfg_type cand;
	logic tick, sync_rise, wr_fire;
	logic [imuos_pkg::IRQ_W-1:0] ev;
	// Processing tick: free 200 Hz, or first sync edge past 90% when synced in SPI mode
	assign sync_rise = sync_in & ~sync_d;
	assign tick = spi_m & sync_seen
		? (sync_rise && pcnt >= 32'(PROC_DIV) - 32'(PROC_DIV / 10))
		: (pcnt >= 32'(PROC_DIV) - 32'h1);
	assign wr_fire = aw_h & w_h & ~bv;
	assign cand = imuos_pkg::imuos_cfg_type'(wd[13:0]);
	assign s_axi_awready = ~aw_h & ~bv;
	assign s_axi_wready = ~w_h & ~bv;
	assign s_axi_arready = ~rv;
	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		next_pcnt = tick ? 32'h0 : pcnt + 32'h1;
		next_scnt = scnt;
		next_ucnt = ucnt;
		next_sync_d = sync_in;
		next_sync_seen = sync_seen;
		next_started = 1'b1;
		next_spi_m = spi_m;
		next_cfg = cfg;
		next_work = work;
		next_outreg = outreg;
		next_seq = seq;
		next_imask = imask;
		next_gp_pend = gp_pend;
		next_uart_go = 1'b0;
		next_drdy = drdy;
		next_aw_h = aw_h;
		next_w_h = w_h;
		next_awa = awa;
		next_wd = wd;
		next_bv = bv;
		next_br = br;
		next_rv = rv;
		next_rr = rr;
		next_rd = rd;
		ev = '0;
		// Port select caught once after reset release
		if (!started)
			next_spi_m = port_sel_in;
		// Sync presence: any rising edge within two sync periods
		if (sync_rise)
		begin
			next_sync_seen = 1'b1;
			next_scnt = 32'h0;
			ev[imuos_pkg::IRQ_SYNC_BIT] = 1'b1;
		end
		else if (scnt >= 32'(2 * SYNC_DIV))
			next_sync_seen = 1'b0;
		else
			next_scnt = scnt + 32'h1;
		// Chain: filter, calibrate, rotate, fault detect, combine
		case (st)
			ST_IDLE:
				if (tick)
					next_st = ST_FILT;
			ST_FILT: next_st = ST_CAL;
			ST_CAL: next_st = ST_ROT;
			ST_ROT: next_st = ST_FAULT;
			ST_FAULT:
			begin
				next_work.fault = sensor_fault_in;
				next_st = ST_COMB;
			end
			ST_COMB:
			begin
				next_seq = seq + 16'h1;
				next_work.seq = seq + 16'h1;
				next_outreg.seq = seq + 16'h1;
				next_outreg.fault = work.fault;
				next_drdy = 1'b1;
				ev[imuos_pkg::IRQ_SPI_BIT] = 1'b1;
				next_st = ST_IDLE;
			end
			default: next_st = ST_IDLE;
		endcase
		if (tick)
			next_drdy = 1'b0;
		// UART pacing at configured rate, or on request
		if (!spi_m)
		begin
			if (cfg.rate != imuos_pkg::R_QUIET)
			begin
				if (ucnt >= imuos_pkg::imuos_uart_div(cfg.rate) - 32'h1)
				begin
					next_ucnt = 32'h0;
					next_uart_go = 1'b1;
				end
				else
					next_ucnt = ucnt + 32'h1;
			end
			if (gp_pend)
			begin
				next_uart_go = 1'b1;
				next_gp_pend = 1'b0;
			end
		end
		if (next_uart_go)
			ev[imuos_pkg::IRQ_UART_BIT] = 1'b1;
		// Write channel capture
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_h = 1'b1;
			next_awa = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_h = 1'b1;
			next_wd = s_axi_wdata;
		end
		if (wr_fire)
		begin
			next_aw_h = 1'b0;
			next_w_h = 1'b0;
			next_bv = 1'b1;
			next_br = imuos_pkg::AXI_OKAY;
			case (awa)
				imuos_pkg::REG_CTRL:
					if (wd[imuos_pkg::CTRL_GET_PKT_BIT])
						next_gp_pend = 1'b1;
				imuos_pkg::REG_CFG:
					if (imuos_pkg::imuos_cfg_ok(cand))
					begin
						next_cfg = cand;
						next_ucnt = 32'h0;
					end
					else
					begin
						next_br = imuos_pkg::AXI_SLVERR;
						ev[imuos_pkg::IRQ_REJ_BIT] = 1'b1;
					end
				imuos_pkg::REG_IRQ_STAT: ;
				imuos_pkg::REG_IRQ_MASK: next_imask = wd[imuos_pkg::IRQ_W-1:0];
				default: next_br = imuos_pkg::AXI_SLVERR;
			endcase
		end
		if (bv && s_axi_bready)
			next_bv = 1'b0;
		// Read channel: single register polling
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rv = 1'b1;
			next_rr = imuos_pkg::AXI_OKAY;
			next_rd = 32'h0;
			case (s_axi_araddr[7:0])
				imuos_pkg::REG_CTRL: next_rd = 32'h0;
				imuos_pkg::REG_CFG: next_rd = {18'h0, cfg};
				imuos_pkg::REG_STATUS:
					next_rd = {27'h0, outreg.fault, sync_seen, drdy};
				imuos_pkg::REG_IRQ_STAT: next_rd = {28'h0, ist};
				imuos_pkg::REG_IRQ_MASK: next_rd = {28'h0, imask};
				imuos_pkg::REG_SEQ: next_rd = {16'h0, outreg.seq};
				imuos_pkg::REG_PORT_SEL: next_rd = {31'h0, spi_m};
				default: next_rr = imuos_pkg::AXI_SLVERR;
			endcase
		end
		else if (rv && s_axi_rready)
			next_rv = 1'b0;
		// Sticky status: set wins over write-one-to-clear
		next_ist = ist;
		if (wr_fire && awa == imuos_pkg::REG_IRQ_STAT)
			next_ist = ist & ~wd[imuos_pkg::IRQ_W-1:0];
		next_ist = next_ist | ev;
	end
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= ST_IDLE;
			pcnt <= 32'h0;
			scnt <= 32'h0;
			ucnt <= 32'h0;
			sync_d <= 1'b0;
			sync_seen <= 1'b0;
			started <= 1'b0;
			spi_m <= 1'b1;
			cfg <= '{imuos_pkg::LEN_DEFAULT, 1'b1, imuos_pkg::R_100,
				imuos_pkg::B38400};
			work <= '0;
			outreg <= '0;
			seq <= 16'h0;
			ist <= '0;
			imask <= '0;
			gp_pend <= 1'b0;
			uart_go <= 1'b0;
			drdy <= 1'b0;
			aw_h <= 1'b0;
			w_h <= 1'b0;
			awa <= 8'h0;
			wd <= 32'h0;
			bv <= 1'b0;
			br <= 2'h0;
			rv <= 1'b0;
			rr <= 2'h0;
			rd <= 32'h0;
		end
		else
		begin
			st <= next_st;
			pcnt <= next_pcnt;
			scnt <= next_scnt;
			ucnt <= next_ucnt;
			sync_d <= next_sync_d;
			sync_seen <= next_sync_seen;
			started <= next_started;
			spi_m <= next_spi_m;
			cfg <= next_cfg;
			work <= next_work;
			outreg <= next_outreg;
			seq <= next_seq;
			ist <= next_ist;
			imask <= next_imask;
			gp_pend <= next_gp_pend;
			uart_go <= next_uart_go;
			drdy <= next_drdy;
			aw_h <= next_aw_h;
			w_h <= next_w_h;
			awa <= next_awa;
			wd <= next_wd;
			bv <= next_bv;
			br <= next_br;
			rv <= next_rv;
			rr <= next_rr;
			rd <= next_rd;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_bvalid = bv;
	assign s_axi_bresp = br;
	assign s_axi_rvalid = rv;
	assign s_axi_rresp = rr;
	assign s_axi_rdata = rd;
	assign port_sel_out = drdy;
	assign port_sel_oe = spi_m & started;
	assign spi_mode = spi_m;
	assign uart_pkt_start = uart_go;
	assign uart_pkt_scaled = cfg.pkt_scaled;
	assign out_seq = outreg.seq;
	assign irq = |(ist & imask);
	// Stage number for the sensor datapath, idle 0 to combine 5
	assign chain_stage = 3'(st);
endmodule : imuos_scheduler

/* File: bench/imuos_scheduler_props.sv */
// Checker for the output scheduler, watching top-level ports only.
// Assumes a bind from the testbench top file.
`timescale 1ns/1ps
module imuos_scheduler_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [2:0] chain_stage,
	input wire logic spi_mode,
	input wire logic port_sel_oe,
	input wire logic uart_pkt_start,
	input wire logic [15:0] out_seq
);
	// ------------------------------------------------------------
	// Port relations
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_pkt_pulse: assert property (uart_pkt_start |=> !uart_pkt_start)
		else $error("packet start wider than one cycle");
	a_uart_only: assert property (uart_pkt_start |-> !spi_mode)
		else $error("packet start in serial peripheral mode");
	a_oe_mode: assert property (port_sel_oe |-> spi_mode)
		else $error("port select driven outside peripheral mode");
	a_mode_fixed: assert property ($past(aresetn) && $past(aresetn, 2)
		|-> $stable(spi_mode)) else $error("port mode changed after start");
	a_chain_order: assert property (chain_stage == 3'h1 |=>
		chain_stage == 3'h2 ##1 chain_stage == 3'h3 ##1 chain_stage == 3'h4
		##1 chain_stage == 3'h5) else $error("chain stage order broken");
	a_seq_step: assert property ($changed(out_seq)
		|-> out_seq == $past(out_seq) + 16'h1) else $error("sequence skipped");
	a_tick_refresh: assert property (chain_stage == 3'h1
		|-> ##[1:8] $changed(out_seq)) else $error("tick without refresh");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write dropped");
endmodule : imuos_scheduler_props

/* File: bench/imuos_host_model.sv */
// Host-side model: sync pulse source and port-select pin with pull-up.
// Assumes the shared system clock.
`timescale 1ns/1ps
module imuos_host_model #(
	parameter int PERIOD = 100
) (
	input wire logic aclk,
	input wire logic sync_en,
	input wire logic sel_ground,
	input wire logic port_sel_out,
	input wire logic port_sel_oe,
	output logic sync_in,
	output logic port_sel_in
);
	int cnt = 0;
	initial sync_in = 1'b0;
	// Pin level: device drive, else ground strap or pull-up
	assign port_sel_in = port_sel_oe ? port_sel_out : !sel_ground;
	// Pulse train, still while disabled
	always @(posedge aclk)
	begin
		cnt <= (!sync_en || cnt == PERIOD - 1) ? 0 : cnt + 1;
		sync_in <= sync_en && cnt < 10;
	end
endmodule : imuos_host_model

/* File: bench/imuos_scheduler_tb.sv */
// Testbench: AXI4-Lite master tasks and hand-written scenarios.
// Assumes shortened counts, PROC_DIV 500 and SYNC_DIV 100.
`timescale 1ns/1ps
module imuos_scheduler_tb;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sync_en = 1'b0;
	logic sel_gnd = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] fault = 3'h0, chain_stage;
	logic sync_in, port_sel_in, port_sel_out, port_sel_oe, spi_mode;
	logic pkt, pkt_scaled, sync_d = 1'b0;
	logic [15:0] out_seq;
	int failures = 0, compares = 0, pk = 0, since = 0;
	always #5 aclk = ~aclk;
	// Packet pulses and distance from last sync rise
	always @(posedge aclk)
	begin
		if (pkt === 1'b1) pk <= pk + 1;
		since <= (sync_in && !sync_d) ? 0 : since + 1;
		sync_d <= sync_in;
	end
	imuos_scheduler #(.PROC_DIV(500), .SYNC_DIV(100)) u_dut (.aclk,
		.aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sync_in, .port_sel_in, .port_sel_out,
		.port_sel_oe, .sensor_fault_in(fault), .chain_stage, .spi_mode,
		.uart_pkt_start(pkt), .uart_pkt_scaled(pkt_scaled), .out_seq, .irq);
	imuos_host_model #(.PERIOD(100)) u_host (.aclk, .sync_en,
		.sel_ground(sel_gnd), .port_sel_out, .port_sel_oe, .sync_in,
		.port_sel_in);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task tmo(inout int n);
		n++;
		if (n > 2000)
		begin
			failures++;
			test_done();
		end
	endtask : tmo
	task w(input int n);
		repeat (n) @(posedge aclk);
	endtask : w
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ha, hw;
		n = 0;
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			tmo(n);
		end while (awvalid || wvalid);
		@(posedge aclk);
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			r = bresp;
			ha = bvalid;
			@(posedge aclk);
			tmo(n);
		end while (!ha);
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic h;
		n = 0;
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			h = arready;
			@(posedge aclk);
			tmo(n);
		end while (!h);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			d = rdata;
			r = rresp;
			h = rvalid;
			@(posedge aclk);
			tmo(n);
		end while (!h);
		rready <= 1'b0;
	endtask : rd
	task tick(output int c);
		c = 0;
		do
		begin
			@(negedge aclk);
			tmo(c);
		end while (chain_stage !== 3'h1);
		@(posedge aclk);
	endtask : tick
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_cfg;
		logic [31:0] d;
		logic [1:0] r;
		w(2);
		chk("spi_mode", spi_mode, 32'h1);
		chk("oe", port_sel_oe, 32'h1);
		rd(8'h40, d, r);
		chk("unmapped", r, imuos_pkg::AXI_SLVERR);
		for (int i = 1; i < 8; i++)
		begin
			wr(imuos_pkg::REG_CFG, {18'h0, 8'h18, 1'b1, 3'(i), 2'h0}, r);
			chk("rate", r, imuos_pkg::AXI_OKAY);
		end
		wr(imuos_pkg::REG_IRQ_MASK, 32'h4, r);
		// 46 chars at 57600 and 100 Hz fit the limit, 47 do not
		wr(imuos_pkg::REG_CFG, {18'h0, 8'h2e, 1'b1, 3'h1, 2'h1}, r);
		chk("fit", r, imuos_pkg::AXI_OKAY);
		wr(imuos_pkg::REG_CFG, {18'h0, 8'h2f, 1'b1, 3'h1, 2'h1}, r);
		chk("wide", r, imuos_pkg::AXI_SLVERR);
		rd(imuos_pkg::REG_CFG, d, r);
		chk("kept", d, {18'h0, 8'h2e, 1'b1, 3'h1, 2'h1});
		w(2);
		chk("irq", irq, 32'h1);
		wr(imuos_pkg::REG_IRQ_STAT, 32'h4, r);
		w(2);
		chk("irq_clr", irq, 32'h0);
	endtask : t_cfg
	task t_tick;
		int c;
		logic [15:0] s;
		logic [31:0] d;
		logic [1:0] r;
		tick(c);
		tick(c);
		chk("period", c, 32'd500);
		chk("drdy_low", port_sel_out, 32'h0);
		fault <= 3'h5;
		w(10);
		s = out_seq;
		chk("drdy", port_sel_out, 32'h1);
		tick(c);
		w(10);
		chk("seq", out_seq - s, 32'h1);
		rd(imuos_pkg::REG_STATUS, d, r);
		chk("fault", d[4:2], 32'h5);
		fault <= 3'h0;
		sync_en <= 1'b1;
		tick(c);
		tick(c);
		chk("sync", since <= 8, 32'h1);
		sync_en <= 1'b0;
	endtask : t_tick
	task t_uart;
		int b;
		logic [1:0] r;
		chk("uart", spi_mode, 32'h0);
		chk("oe_off", port_sel_oe, 32'h0);
		wr(imuos_pkg::REG_CFG, {18'h0, 8'h18, 1'b1, 3'h0, 2'h0}, r);
		b = pk;
		wr(imuos_pkg::REG_CTRL, 32'h1, r);
		wr(imuos_pkg::REG_CTRL, 32'h1, r);
		w(10);
		chk("polled", pk - b, 32'h2);
		chk("scaled", pkt_scaled, 32'h1);
		wr(imuos_pkg::REG_CFG, {18'h0, 8'h18, 1'b0, 3'h0, 2'h0}, r);
		chk("unscaled", pkt_scaled, 32'h0);
	endtask : t_uart
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_cfg();
		t_tick();
		sel_gnd <= 1'b1;
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		w(2);
		t_uart();
		test_done();
	end
endmodule : imuos_scheduler_tb
bind imuos_scheduler imuos_scheduler_props u_props (.aclk, .aresetn,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .chain_stage,
	.spi_mode, .port_sel_oe, .uart_pkt_start, .out_seq);
